//--- cfg_if.sv
// interface: decoded configuration fields between bank and timer
`timescale 1ns/1ps
interface cfg_if;
    logic [2:0] rx_time;
    logic       qualifier;
    logic       cs_term;
    modport bank (output rx_time, output qualifier, output cs_term);
    modport timer (input rx_time, input qualifier, input cs_term);
endinterface

//--- host_model.sv
// partner model: host register master and rc oscillator enable
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_i,
    input  wire logic       rc_en_i,
    input  wire logic [7:0] rdata_i,
    output logic [5:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wdata_o,
    output logic            rc_tick_o
);
    initial begin
        addr_o    = 6'h00;
        wr_o      = 1'b0;
        wdata_o   = 8'h00;
        rc_tick_o = 1'b0;
        // odd-ns phase keeps rc edges off every clock edge
        #1;
        // rc clock stands still until software enables it
        forever #316 rc_tick_o = rc_en_i & ~rc_tick_o;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wr_o    <= 1'b1;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask
    // read data is registered, so one edge after the address
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask
endmodule // host_model

//--- modem_cfg_pkg.sv
// package: register map, field layout, reset values and timing constants
package modem_cfg_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_MODEM_CONFIG_ONE    = 6'h13;
    localparam logic [5:0] ADDR_MODEM_CONFIG_ZERO   = 6'h14;
    localparam logic [5:0] ADDR_FREQUENCY_DEVIATION = 6'h15;
    localparam logic [5:0] ADDR_RADIO_STATE_CFG_TWO = 6'h16;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FEC_BIT       = 7;
    localparam int PRE_LSB       = 4;
    localparam int SPC_E_LSB     = 0;
    localparam int DEV_E_LSB     = 4;
    localparam int DEV_M_LSB     = 0;
    localparam int CS_TERM_BIT   = 4;
    localparam int QUAL_BIT      = 3;
    localparam int RX_TIME_LSB   = 0;
    // ----------------------------------------------------------------
    // reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MODEM_ONE  = 8'h22;
    localparam logic [7:0] RST_MODEM_ZERO = 8'hf8;
    localparam logic [7:0] RST_DEVIATION  = 8'h47;
    localparam logic [7:0] RST_RSC_TWO    = 8'h07;
    localparam logic [7:0] MASK_MODEM_ONE = 8'hf3;
    localparam logic [7:0] MASK_DEVIATION = 8'h77;
    localparam logic [7:0] MASK_RSC_TWO   = 8'h1f;
    // ----------------------------------------------------------------
    // timing and arithmetic constants
    // ----------------------------------------------------------------
    localparam logic [2:0] RX_TIME_NONE    = 3'h7;
    localparam int         ASK_CS_SYMBOLS  = 8;
    localparam int         SPACING_OFFSET  = 256;
    localparam int         DEV_OFFSET      = 8;
    localparam int         EVENT_MSBS_MAX  = 13;
    localparam int         EVENT_W         = 16;
    localparam int         SPC_FRAC_BITS   = 18;
    localparam int         DEV_FRAC_BITS   = 17;
    localparam int         CLK_PERIOD_NS   = 40;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HUNT = 4'b0010,
        ST_KEEP = 4'b0100,
        ST_STOP = 4'b1000
    } rx_state_t;
endpackage

//--- modem_config_rx_timeout.sv
// module: modem configuration and receive-timeout register bank
`timescale 1ns/1ps
// Behaviour
// - fec with interleaving is enabled only for fixed-length packets.
// - the preamble code maps to 2,3,4,6,8,12,16,24 bytes, reset code 2.
// - spacing mantissa resets to 0xf8, exponent in bits 1:0 resets to 2.
// - channel offset is channel times xtal/2^18 times (256+m) times 2^e.
// - fsk deviation is xtal/2^17 times (8+m) times 2^e, resets 7 and 4.
// - with msk the deviation mantissa gives the phase-change fraction.
// - carrier-sense termination ends rx early, after 8 symbols on ask.
// - at expiry rx keeps on sync, or on preamble quality when qualified.
// - the 3-bit receive-time field, reset 7, times the sync search.
// - timeout scales the event period, halving per code; code 7 never times out.
// - count is the event period's 13 msbs at code 0, down to 7 at code 6.
module modem_config_rx_timeout
    import modem_cfg_pkg::*;
(
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    input  wire logic [5:0]                         reg_addr_i,
    input  wire logic                               reg_wr_i,
    input  wire logic [7:0]                         reg_wdata_i,
    output logic [7:0]                              reg_rdata_o,
    input  wire logic                               packet_length_setting_i,
    input  wire logic                               msk_i,
    input  wire logic                               ask_i,
    input  wire logic [7:0]                         channel_number_i,
    input  wire logic [modem_cfg_pkg::EVENT_W-1:0]  wake_event_period_i,
    input  wire logic                               rx_start_i,
    input  wire logic                               rx_done_i,
    input  wire logic                               rc_tick_i,
    input  wire logic                               sym_tick_i,
    input  wire logic                               sync_found_i,
    input  wire logic                               preamble_quality_indication_i,
    input  wire logic                               carrier_sense_i,
    output logic                                    error_correction_enable_o,
    output logic [4:0]                              preamble_bytes_o,
    output logic [31:0]                             channel_offset_o,
    output logic [31:0]                             deviation_o,
    output logic [2:0]                              msk_phase_fraction_o,
    output logic                                    rx_stop_o,
    output logic                                    rx_keep_o
);
    import modem_cfg_pkg::*;
    logic [7:0]  mdm1_q;
    logic [7:0]  mdm0_q;
    logic [7:0]  dev_q;
    logic [7:0]  rsc2_q;
    logic [4:0]  pre_bytes;
    logic [1:0]  spc_e;
    logic [2:0]  dev_e;
    logic [2:0]  dev_m;
    logic [31:0] spc_prod;
    logic [31:0] dev_raw;
    logic        rx_start_q;
    logic        sync_meta_q;
    logic        sync_q;
    logic        qual_meta_q;
    logic        qual_q;
    logic        cs_meta_q;
    logic        cs_q;
    logic        done_meta_q;
    logic        done_q;
    logic        rc_meta_q;
    logic        rc_q;
    logic        rc_prev_q;
    logic        sym_meta_q;
    logic        sym_q;
    logic        sym_prev_q;
    logic        tmr_stop;
    logic        tmr_keep;
    cfg_if       cfg ();
    // ----------------------------------------------------------------
    // register writes; reserved bits masked so they stay zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mdm1_q <= RST_MODEM_ONE;
            mdm0_q <= RST_MODEM_ZERO;
            dev_q  <= RST_DEVIATION;
            rsc2_q <= RST_RSC_TWO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_MODEM_CONFIG_ONE:    mdm1_q <= reg_wdata_i & MASK_MODEM_ONE;
                ADDR_MODEM_CONFIG_ZERO:   mdm0_q <= reg_wdata_i;
                ADDR_FREQUENCY_DEVIATION: dev_q  <= reg_wdata_i & MASK_DEVIATION;
                ADDR_RADIO_STATE_CFG_TWO: rsc2_q <= reg_wdata_i & MASK_RSC_TWO;
                default: ;
            endcase
        end
    end
    // unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) reg_rdata_o <= 8'h00;
        else begin
            case (reg_addr_i)
                ADDR_MODEM_CONFIG_ONE:    reg_rdata_o <= mdm1_q;
                ADDR_MODEM_CONFIG_ZERO:   reg_rdata_o <= mdm0_q;
                ADDR_FREQUENCY_DEVIATION: reg_rdata_o <= dev_q;
                ADDR_RADIO_STATE_CFG_TWO: reg_rdata_o <= rsc2_q;
                default:                  reg_rdata_o <= 8'h00;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    assign spc_e = mdm1_q[SPC_E_LSB +: 2];
    assign dev_e = dev_q[DEV_E_LSB +: 3];
    assign dev_m = dev_q[DEV_M_LSB +: 3];
    assign cfg.rx_time   = rsc2_q[RX_TIME_LSB +: 3];
    assign cfg.qualifier = rsc2_q[QUAL_BIT];
    assign cfg.cs_term   = rsc2_q[CS_TERM_BIT];
    always_comb begin
        case (mdm1_q[PRE_LSB +: 3])
            3'h0:    pre_bytes = 5'h02;
            3'h1:    pre_bytes = 5'h03;
            3'h2:    pre_bytes = 5'h04;
            3'h3:    pre_bytes = 5'h06;
            3'h4:    pre_bytes = 5'h08;
            3'h5:    pre_bytes = 5'h0c;
            3'h6:    pre_bytes = 5'h10;
            default: pre_bytes = 5'h18;
        endcase
    end
    // results are in units of f_xtal / 2^18 and f_xtal / 2^17
    assign spc_prod = (32'(channel_number_i)
                      * (32'(SPACING_OFFSET) + 32'(mdm0_q))) << spc_e;
    assign dev_raw  = 32'((4'(DEV_OFFSET) + {1'b0, dev_m})) << dev_e;
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_meta_q <= 1'b0;
            sync_q      <= 1'b0;
            qual_meta_q <= 1'b0;
            qual_q      <= 1'b0;
            cs_meta_q   <= 1'b0;
            cs_q        <= 1'b0;
            done_meta_q <= 1'b0;
            done_q      <= 1'b0;
            rc_meta_q   <= 1'b0;
            rc_q        <= 1'b0;
            rc_prev_q   <= 1'b0;
            sym_meta_q  <= 1'b0;
            sym_q       <= 1'b0;
            sym_prev_q  <= 1'b0;
            rx_start_q  <= 1'b0;
        end else begin
            sync_meta_q <= sync_found_i;
            sync_q      <= sync_meta_q;
            qual_meta_q <= preamble_quality_indication_i;
            qual_q      <= qual_meta_q;
            cs_meta_q   <= carrier_sense_i;
            cs_q        <= cs_meta_q;
            done_meta_q <= rx_done_i;
            done_q      <= done_meta_q;
            rc_meta_q   <= rc_tick_i;
            rc_q        <= rc_meta_q;
            rc_prev_q   <= rc_q;
            sym_meta_q  <= sym_tick_i;
            sym_q       <= sym_meta_q;
            sym_prev_q  <= sym_q;
            rx_start_q  <= rx_start_i;
        end
    end
    // ----------------------------------------------------------------
    // timeout engine; counts rc edges, so the rc must run for 0..6
    // ----------------------------------------------------------------
    rx_timeout u_rx_timeout (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .cfg        (cfg),
        .event_i    (wake_event_period_i),
        .start_i    (rx_start_q),
        .rc_tick_i  (rc_q & ~rc_prev_q),
        .sym_tick_i (sym_q & ~sym_prev_q),
        .ask_i      (ask_i),
        .sync_i     (sync_q),
        .quality_i  (qual_q),
        .cs_i       (cs_q),
        .done_i     (done_q),
        .stop_o     (tmr_stop),
        .keep_o     (tmr_keep)
    );
    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            error_correction_enable_o <= 1'b0;
            preamble_bytes_o          <= 5'h04;
            channel_offset_o          <= 32'h0000_0000;
            deviation_o               <= 32'h0000_0000;
            msk_phase_fraction_o      <= 3'h0;
            rx_stop_o                 <= 1'b0;
            rx_keep_o                 <= 1'b0;
        end else begin
            // variable-length packets cannot carry interleaved fec
            error_correction_enable_o <= mdm1_q[FEC_BIT]
                                         && !packet_length_setting_i;
            preamble_bytes_o          <= pre_bytes;
            channel_offset_o          <= spc_prod[31:0];
            deviation_o               <= msk_i ? 32'h0 : dev_raw;
            msk_phase_fraction_o      <= msk_i ? dev_m : 3'h0;
            rx_stop_o                 <= tmr_stop;
            rx_keep_o                 <= tmr_keep;
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_FEC_FIXED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        error_correction_enable_o |-> $past(!packet_length_setting_i))
        else $error("fec on with variable length");
    AST_PREAMBLE_24: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mdm1_q[6:4] == 3'h7 |=> preamble_bytes_o == 5'h18)
        else $error("code 7 preamble must be 24 bytes");
    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_wr_i ##1 1'b1 |-> mdm1_q[3:2] == 2'h0 && dev_q[7] == 1'b0
        && dev_q[3] == 1'b0 && rsc2_q[7:5] == 3'h0)
        else $error("reserved bits must stay zero");
    AST_MSK_FRACTION: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        msk_i |=> deviation_o == 32'h0 && msk_phase_fraction_o == $past(dev_m))
        else $error("msk must reuse deviation mantissa");
    AST_DEV_RESET: assert property (@(posedge clk_i)
        !rst_n_i |=> dev_q == 8'h47 && mdm0_q == 8'hf8 && rsc2_q == 8'h07)
        else $error("reset values wrong");
    COV_FEC: cover property (@(posedge clk_i) error_correction_enable_o);
    COV_MSK: cover property (@(posedge clk_i) msk_i && msk_phase_fraction_o != 3'h0);
endmodule // modem_config_rx_timeout

//--- rx_timeout.sv
// module: receive sync-search timeout counter on the rc tick
`timescale 1ns/1ps
module rx_timeout
    import modem_cfg_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    cfg_if.timer                            cfg,
    input  wire logic [EVENT_W-1:0]         event_i,
    input  wire logic                       start_i,
    input  wire logic                       rc_tick_i,
    input  wire logic                       sym_tick_i,
    input  wire logic                       ask_i,
    input  wire logic                       sync_i,
    input  wire logic                       quality_i,
    input  wire logic                       cs_i,
    input  wire logic                       done_i,
    output logic                            stop_o,
    output logic                            keep_o
);
    import modem_cfg_pkg::*;
    rx_state_t         state_q;
    logic [15:0]       cnt_q;
    logic [3:0]        sym_q;
    logic [15:0]       load;
    logic              expired;
    logic              cs_fail;
    // ----------------------------------------------------------------
    // timeout length: 13 msbs at code 0, one fewer per code
    // ----------------------------------------------------------------
    always_comb begin
        load = 16'(event_i >> (EVENT_W - EVENT_MSBS_MAX + 32'(cfg.rx_time)));
    end
    assign expired = (state_q == ST_HUNT) && cfg.rx_time != RX_TIME_NONE
                     && rc_tick_i && cnt_q <= 16'h0001;
    // ask: no carrier in the first symbols ends rx
    assign cs_fail = cfg.cs_term && ((ask_i && sym_tick_i && !cs_i
                     && sym_q == 4'(ASK_CS_SYMBOLS - 1))
                     || (!ask_i && !cs_i));
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: if (start_i) state_q <= ST_HUNT;
                ST_HUNT: begin
                    if (done_i) state_q <= ST_IDLE;
                    else if (cs_fail) state_q <= ST_STOP;
                    else if (expired) begin
                        // sync always keeps; quality only when qualified
                        if (sync_i || (cfg.qualifier && quality_i))
                            state_q <= ST_KEEP;
                        else
                            state_q <= ST_STOP;
                    end
                end
                ST_KEEP: if (done_i) state_q <= ST_IDLE;
                ST_STOP: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) cnt_q <= 16'h0000;
        else if (start_i && state_q == ST_IDLE) cnt_q <= load;
        else if (rc_tick_i && cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) sym_q <= 4'h0;
        else if (state_q != ST_HUNT) sym_q <= 4'h0;
        else if (sym_tick_i && sym_q != 4'hf) sym_q <= sym_q + 4'h1;
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stop_o <= 1'b0;
            keep_o <= 1'b0;
        end else begin
            stop_o <= (state_q == ST_STOP);
            keep_o <= (state_q == ST_KEEP);
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_NO_TIMEOUT_CODE7: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_HUNT && cfg.rx_time == RX_TIME_NONE && !cfg.cs_term
         && !done_i) |=> state_q == ST_HUNT)
        else $error("code 7 must not time out");
    AST_QUAL_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (expired && !cs_fail && !done_i && !sync_i && cfg.qualifier
         && quality_i) |=> state_q == ST_KEEP)
        else $error("qualified preamble quality must keep rx");
    AST_NOQUAL_STOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (expired && !cs_fail && !done_i && !sync_i && !cfg.qualifier)
        |=> state_q == ST_STOP ##1 stop_o)
        else $error("no sync and no qualifier must stop rx");
    AST_LOAD_MSBS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_IDLE && start_i && cfg.rx_time == 3'h0)
        |=> cnt_q == 16'(event_i >> 3) || $changed(event_i))
        else $error("code 0 must load 13 msbs");
    AST_CS_TERM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_HUNT && !done_i && cfg.cs_term && !ask_i && !cs_i)
        |=> state_q == ST_STOP)
        else $error("missing carrier must end rx");
    COV_KEEP: cover property (@(posedge clk_i) state_q == ST_KEEP);
    COV_STOP: cover property (@(posedge clk_i) state_q == ST_STOP);
    COV_ASK: cover property (@(posedge clk_i) cs_fail && ask_i);
endmodule // rx_timeout

//--- tb_modem_config_rx_timeout.sv
// testbench: register bank and receive timeout against a bench model
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_modem_config_rx_timeout;
    import modem_cfg_pkg::*;
    logic        clk_i = 0, rst_n_i = 0, rc_en = 0, reg_wr_i, rc_tick_i;
    logic [5:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, channel_number_i = 8'h00;
    logic [15:0] wake_event_period_i = 16'h0000;
    logic        packet_length_setting_i = 0, msk_i = 0, ask_i = 0;
    logic        rx_start_i = 0, rx_done_i = 0, sym_tick_i = 0;
    logic        sync_found_i = 0, preamble_quality_indication_i = 0;
    logic        carrier_sense_i = 0, error_correction_enable_o;
    logic [4:0]  preamble_bytes_o;
    logic [2:0]  msk_phase_fraction_o;
    logic [31:0] channel_offset_o, deviation_o;
    logic        rx_stop_o, rx_keep_o;
    int          fails = 0, n_checks = 0, n_stop = 0, seed = 32'h796b;
    int          pre_tab [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
    logic [7:0]  mreg [6'h13:6'h16] = '{8'h22, 8'hf8, 8'h47, 8'h07};

    modem_config_rx_timeout dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
        .reg_wdata_i, .reg_rdata_o, .packet_length_setting_i, .msk_i, .ask_i,
        .channel_number_i, .wake_event_period_i, .rx_start_i, .rx_done_i,
        .rc_tick_i, .sym_tick_i, .sync_found_i, .carrier_sense_i,
        .preamble_quality_indication_i, .error_correction_enable_o,
        .preamble_bytes_o, .channel_offset_o, .deviation_o,
        .msk_phase_fraction_o, .rx_stop_o, .rx_keep_o);
    host_model host (.clk_i, .rc_en_i(rc_en), .rdata_i(reg_rdata_o),
        .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
        .rc_tick_o(rc_tick_i));

    always #20 clk_i = ~clk_i;
    // stop is a one-cycle pulse, so count every one of them
    always @(posedge clk_i) if (rx_stop_o === 1'b1) n_stop <= n_stop + 1;
    // ----------------------------------------------------------------
    // bench model
    // ----------------------------------------------------------------
    function automatic logic [7:0] wmask(input logic [5:0] a);
        case (a)
            6'h13:   return 8'hf3;
            6'h15:   return 8'h77;
            6'h16:   return 8'h1f;
            default: return 8'hff;
        endcase
    endfunction
    function automatic logic [7:0] mdl(input logic [5:0] a);
        return (a >= 6'h13 && a <= 6'h16) ? mreg[a] : 8'h00;
    endfunction
    task automatic check_dec;
        int m1, m0, dv;
        m1 = mreg[6'h13];
        m0 = mreg[6'h14];
        dv = mreg[6'h15];
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(error_correction_enable_o, m1[7] & ~packet_length_setting_i)
        `CHK(preamble_bytes_o, 5'(pre_tab[m1[6:4]]))
        `CHK(channel_offset_o, 32'((channel_number_i * (256 + m0)) << m1[1:0]))
        `CHK(deviation_o, msk_i ? 32'h0 : 32'((8 + dv[2:0]) << dv[6:4]))
        `CHK(msk_phase_fraction_o, msk_i ? 3'(dv[2:0]) : 3'h0)
    endtask
    task automatic set_rsc(input logic [7:0] v);
        host.wr(6'h16, v);
        mreg[6'h16] = v & wmask(6'h16);
    endtask
    task automatic start_rx;
        @(posedge clk_i);
        rx_start_i <= 1'b1;
        @(posedge clk_i);
        rx_start_i <= 1'b0;
    endtask
    task automatic end_rx;
        @(posedge clk_i);
        rx_done_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rx_done_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(rx_keep_o, 1'b0)
    endtask
    task automatic run_rx(input int code, input int sel);
        int   n, cyc, s0;
        logic prev, kx;
        kx = (sel == 0) | (sel == 3);
        @(posedge clk_i);
        sync_found_i <= (sel == 0);
        preamble_quality_indication_i <= sel[0];
        set_rsc({4'h0, sel[1], code[2:0]});
        // start mid rc period so no rc edge races the load
        wait (rc_tick_i);
        wait (!rc_tick_i);
        start_rx;
        n = 0;
        cyc = 0;
        s0 = n_stop;
        prev = rc_tick_i;
        while (n_stop == s0 && rx_keep_o !== 1'b1 && cyc < 4000
               && !(code == 7 && n == 24)) begin
            @(posedge clk_i);
            #1;
            n += int'(rc_tick_i & ~prev);
            prev = rc_tick_i;
            cyc++;
        end
        `CHK(cyc < 4000, 1'b1)
        if (code == 7) begin
            `CHK(rx_keep_o, 1'b0)
        end else begin
            `CHK(n, int'(wake_event_period_i >> (3 + code)))
            `CHK(rx_keep_o, kx)
        end
        end_rx;
        `CHK(n_stop - s0, int'(code != 7 && !kx))
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        int         k, s;
        logic [5:0] a;
        logic [7:0] d, r;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rc_en   <= 1'b1;
        for (k = 6'h12; k <= 6'h17; k++) begin
            host.rd(6'(k), r);
            `CHK(r, mdl(6'(k)))
        end
        check_dec;
        for (k = 0; k < 8; k++) begin
            host.wr(6'h13, {1'b1, 3'(k), 2'b11, 2'(k)});
            mreg[6'h13] = {1'b1, 3'(k), 2'b00, 2'(k)};
            packet_length_setting_i <= k[0];
            check_dec;
        end
        repeat (24) begin
            @(posedge clk_i);
            a = 6'h12 + 6'($unsigned($random(seed)) % 6);
            d = 8'($random(seed));
            msk_i <= 1'($random(seed));
            channel_number_i <= 8'($random(seed));
            host.wr(a, d);
            if (a >= 6'h13 && a <= 6'h16) mreg[a] = d & wmask(a);
            host.rd(a, r);
            `CHK(r, mdl(a))
            check_dec;
        end
        @(posedge clk_i);
        wake_event_period_i <= 16'h0400 + 16'($unsigned($random(seed)) % 128);
        // wake-on-radio stays off, so any wake resolution is legal
        for (k = 0; k < 8; k++) run_rx(k, (k == 7) ? 1 : k % 4);
        // early end on missing carrier: at once, or after 8 symbols on ask
        @(posedge clk_i);
        sync_found_i <= 1'b0;
        s = n_stop;
        set_rsc(8'h10);
        start_rx;
        repeat (10) @(posedge clk_i);
        #1;
        `CHK(n_stop - s, 1)
        @(posedge clk_i);
        ask_i <= 1'b1;
        s = n_stop;
        start_rx;
        for (k = 1; k <= 8; k++) begin
            repeat (5) @(posedge clk_i);
            sym_tick_i <= 1'b1;
            repeat (8) @(posedge clk_i);
            sym_tick_i <= 1'b0;
            #1;
            `CHK(n_stop - s, int'(k == 8))
        end
        end_sim;
    end
    initial begin
        #800000;
        fails++;
        end_sim;
    end
endmodule // tb_modem_config_rx_timeout
